/* rtl/hrap_port.sv */
// Parallel and serial host access port with shared address pointer
`timescale 1ns/1ps
module hrap_port
  import hrap_pkg::*;
#(
  parameter logic [hrap_pkg::SER_ADDR_W-1:0] SLAVE_ADDR = hrap_pkg::SLAVE_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic serial_iface_select_strap,
  input wire logic chip_select_n,
  input wire logic host_read_select,
  input wire logic pointer_select,
  input wire logic [hrap_pkg::DATA_W-1:0] host_data_bus_in,
  output logic [hrap_pkg::DATA_W-1:0] host_data_bus_out,
  output logic [hrap_pkg::DATA_W-1:0] host_data_bus_oe,
  output logic host_ready_n_out,
  output logic host_ready_n_oe,
  input wire logic pointer_step_off,
  output logic [hrap_pkg::PTR_W-1:0] reg_addr,
  output logic reg_wr_en,
  output logic [hrap_pkg::DATA_W-1:0] reg_wr_data,
  output logic reg_rd_en,
  input wire logic [hrap_pkg::DATA_W-1:0] reg_rd_data
);
  import hrap_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  logic [PIN_W-1:0] pins_raw;
  logic [PIN_W-1:0] pins;
  logic serial_mode;
  logic cs_low;
  logic scl;
  logic sda;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // Chip select enters the flops inverted so that reset leaves it deselected
  assign pins_raw = {serial_iface_select_strap, pointer_select, host_read_select, !chip_select_n, host_data_bus_in};

  hrap_sync #(.WIDTH(PIN_W)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d(pins_raw),
    .q(pins)
  );

  assign serial_mode = pins[PIN_STRAP];
  assign cs_low = pins[PIN_CS] && !serial_mode;
  assign scl = !pins[PIN_CS];
  assign sda = pins[PIN_SDA];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl;
      sda_d <= sda;
    end
  end

  assign scl_rise = serial_mode && scl && !scl_d;
  assign scl_fall = serial_mode && !scl && scl_d;
  assign start_cond = serial_mode && scl && scl_d && sda_d && !sda;
  assign stop_cond = serial_mode && scl && scl_d && !sda_d && sda;

  // ----------------------------------------------------------------
  // Parallel port
  // ----------------------------------------------------------------
  hrap_par_state_t par_state;
  logic [PTR_W-1:0] ptr;
  logic par_read;
  logic par_psel;
  logic [DATA_W-1:0] par_wdata;
  logic [DATA_W-1:0] par_out;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      par_state <= P_IDLE;
      par_read <= 1'b0;
      par_psel <= 1'b0;
      par_wdata <= BYTE_ZERO;
    end
    else
    begin
      case (par_state)
        P_IDLE:
        begin
          if (cs_low)
          begin
            par_read <= pins[PIN_RW];
            par_psel <= pins[PIN_PSEL];
            par_wdata <= pins[PIN_DATA_LSB +: DATA_W];
            par_state <= P_ACCESS;
          end
        end
        P_ACCESS:
        begin
          par_state <= par_read ? P_FETCH : P_DONE;
        end
        P_FETCH:
        begin
          par_state <= P_DONE;
        end
        P_DONE:
        begin
          if (!cs_low)
          begin
            par_state <= P_IDLE;
          end
        end
        default:
        begin
          par_state <= P_IDLE;
        end
      endcase
    end
  end

  // Read data register for the parallel bus
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      par_out <= BYTE_ZERO;
    end
    else if (par_state == P_FETCH)
    begin
      par_out <= par_psel ? ptr : reg_rd_data;
    end
  end

  assign host_ready_n_oe = cs_low;
  assign host_ready_n_out = (par_state != P_DONE);

  // ----------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------
  hrap_ser_state_t ser_state;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [DATA_W-1:0] shift;
  logic addr_phase;
  logic ser_read;
  logic first_data;
  logic master_ack;
  logic sda_drive_low;
  logic [DATA_W-1:0] rd_buf;
  logic rd_buf_load;
  logic ser_ptr_load;
  logic ser_wr;
  logic ser_rd;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ser_state <= S_IDLE;
      bit_cnt <= BIT_CNT_ZERO;
      shift <= BYTE_ZERO;
      addr_phase <= 1'b0;
      ser_read <= 1'b0;
      first_data <= 1'b0;
      master_ack <= 1'b0;
    end
    else if (!serial_mode || stop_cond)
    begin
      ser_state <= S_IDLE;
    end
    else if (start_cond)
    begin
      ser_state <= S_RX;
      bit_cnt <= BIT_CNT_ZERO;
      addr_phase <= 1'b1;
      first_data <= 1'b1;
    end
    else
    begin
      case (ser_state)
        S_IDLE:
        begin
          bit_cnt <= BIT_CNT_ZERO;
        end
        S_RX:
        begin
          if (scl_rise)
          begin
            shift <= {shift[DATA_W-2:0], sda};
            bit_cnt <= bit_cnt + BIT_CNT_ONE;
          end
          else if (scl_fall && bit_cnt == BITS_PER_BYTE)
          begin
            if (addr_phase && shift[DATA_W-1:1] != SLAVE_ADDR)
            begin
              ser_state <= S_IDLE;
            end
            else
            begin
              ser_state <= S_ACK;
              if (addr_phase)
              begin
                ser_read <= shift[0];
              end
            end
          end
        end
        S_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt <= BIT_CNT_ZERO;
            if (!addr_phase && !ser_read)
            begin
              first_data <= 1'b0;
            end
            addr_phase <= 1'b0;
            if (ser_read)
            begin
              ser_state <= S_TX;
              shift <= {1'b0, ptr[SER_ADDR_W-1:0]};
            end
            else
            begin
              ser_state <= S_RX;
            end
          end
        end
        S_TX:
        begin
          if (scl_fall)
          begin
            shift <= {shift[DATA_W-2:0], 1'b0};
            bit_cnt <= bit_cnt + BIT_CNT_ONE;
            if (bit_cnt + BIT_CNT_ONE == BITS_PER_BYTE)
            begin
              ser_state <= S_MACK;
            end
          end
        end
        S_MACK:
        begin
          if (scl_rise)
          begin
            master_ack <= !sda;
          end
          else if (scl_fall)
          begin
            bit_cnt <= BIT_CNT_ZERO;
            first_data <= 1'b0;
            if (master_ack)
            begin
              ser_state <= S_TX;
              shift <= rd_buf;
            end
            else
            begin
              ser_state <= S_IDLE;
            end
          end
        end
        default:
        begin
          ser_state <= S_IDLE;
        end
      endcase
    end
  end

  // Register accesses raised by the serial side
  assign ser_ptr_load = ser_state == S_RX && scl_fall && bit_cnt == BITS_PER_BYTE
    && !addr_phase && first_data;
  assign ser_wr = ser_state == S_RX && scl_fall && bit_cnt == BITS_PER_BYTE
    && !addr_phase && !first_data;
  assign ser_rd = ser_state == S_TX && scl_fall && bit_cnt + BIT_CNT_ONE == BITS_PER_BYTE;

  // SDA pulled low for acknowledge or a zero data bit, changed after SCL falls
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sda_drive_low <= 1'b0;
    end
    else if (!serial_mode || stop_cond || start_cond)
    begin
      sda_drive_low <= 1'b0;
    end
    else if (scl_fall)
    begin
      if (ser_state == S_RX && bit_cnt == BITS_PER_BYTE && !(addr_phase && shift[DATA_W-1:1] != SLAVE_ADDR))
      begin
        sda_drive_low <= 1'b1;
      end
      else if (ser_state == S_ACK && ser_read)
      begin
        sda_drive_low <= 1'b1;
      end
      else if (ser_state == S_TX && bit_cnt + BIT_CNT_ONE != BITS_PER_BYTE)
      begin
        sda_drive_low <= !shift[DATA_W-2];
      end
      else if (ser_state == S_MACK && master_ack)
      begin
        sda_drive_low <= !rd_buf[DATA_W-1];
      end
      else
      begin
        sda_drive_low <= 1'b0;
      end
    end
  end

  // Prefetched register for the next serial read byte
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd_buf <= BYTE_ZERO;
      rd_buf_load <= 1'b0;
    end
    else
    begin
      rd_buf_load <= ser_rd;
      if (rd_buf_load)
      begin
        rd_buf <= reg_rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Address pointer and register strobes
  // ----------------------------------------------------------------
  logic par_access;
  logic any_access;

  assign par_access = par_state == P_ACCESS && !par_psel;
  assign any_access = par_access || ser_wr || ser_rd;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ptr <= PTR_RESET;
    end
    else if (par_state == P_ACCESS && par_psel && !par_read)
    begin
      ptr <= par_wdata;
    end
    else if (ser_ptr_load)
    begin
      ptr <= {1'b0, shift[SER_ADDR_W-1:0]};
    end
    else if (any_access && !pointer_step_off)
    begin
      ptr <= ptr + PTR_STEP;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reg_addr <= PTR_RESET;
      reg_wr_en <= 1'b0;
      reg_rd_en <= 1'b0;
      reg_wr_data <= BYTE_ZERO;
    end
    else
    begin
      reg_addr <= ptr;
      reg_wr_en <= (par_access && !par_read) || ser_wr;
      reg_rd_en <= (par_access && par_read) || ser_rd;
      reg_wr_data <= ser_wr ? shift : par_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Shared data pins
  // ----------------------------------------------------------------
  assign host_data_bus_out = serial_mode ? BYTE_ZERO : par_out;
  assign host_data_bus_oe = serial_mode ? {{(DATA_W-1){1'b0}}, sda_drive_low}
    : ((cs_low && par_read && (par_state == P_DONE)) ? BUS_DRIVE_ALL : BYTE_ZERO);
endmodule : hrap_port

/* include/hrap_pkg.sv */
// Shared constants for the host register access port
package hrap_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int PTR_W = 8;
  localparam int SER_ADDR_W = 7;
  localparam int BIT_CNT_W = 4;
  localparam int PIN_W = 12;
  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [BIT_CNT_W-1:0] BITS_PER_BYTE = 4'h8;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 4'h1;
  localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;
  localparam logic [PTR_W-1:0] PTR_STEP = 8'h01;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BUS_DRIVE_ALL = 8'hff;
  localparam logic [SER_ADDR_W-1:0] SLAVE_ADDR_DEFAULT = 7'h2a;
  // ----------------------------------------------------------------
  // Pin vector field positions
  // ----------------------------------------------------------------
  localparam int PIN_DATA_LSB = 0;
  localparam int PIN_SDA = 0;
  localparam int PIN_CS = 8;
  localparam int PIN_RW = 9;
  localparam int PIN_PSEL = 10;
  localparam int PIN_STRAP = 11;
  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {P_IDLE, P_ACCESS, P_FETCH, P_DONE} hrap_par_state_t;
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_MACK} hrap_ser_state_t;
endpackage : hrap_pkg

/* rtl/hrap_sync.sv */
// Two-stage synchroniser for a group of pins
`timescale 1ns/1ps
module hrap_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : hrap_sync

/* verification/hrap_port_monitor.sv */
// Protocol checker for the host register access port
`timescale 1ns/1ps
module hrap_port_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic serial_iface_select_strap,
  input wire logic chip_select_n,
  input wire logic host_read_select,
  input wire logic pointer_select,
  input wire logic [7:0] host_data_bus_oe,
  input wire logic host_ready_n_out,
  input wire logic host_ready_n_oe,
  input wire logic pointer_step_off,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_rdy_rise;
    $rose(host_ready_n_oe) |-> !chip_select_n && !serial_iface_select_strap;
  endproperty
  a_rdy_rise: assert property (p_rdy_rise) else $error("ready enabled unselected");
  property p_rdy_rel;
    chip_select_n [*5] |-> !host_ready_n_oe;
  endproperty
  a_rdy_rel: assert property (p_rdy_rel) else $error("ready not released");
  property p_answer;
    $fell(chip_select_n) && !serial_iface_select_strap |-> ##[2:10] host_ready_n_oe && !host_ready_n_out;
  endproperty
  a_answer: assert property (p_answer) else $error("ready late");
  property p_bus_rel;
    (chip_select_n && !serial_iface_select_strap) [*5] |-> host_data_bus_oe == 8'h00;
  endproperty
  a_bus_rel: assert property (p_bus_rel) else $error("bus not released");
  property p_drive;
    host_data_bus_oe == 8'hff |-> host_ready_n_oe && !host_ready_n_out && host_read_select;
  endproperty
  a_drive: assert property (p_drive) else $error("bus driven outside read");
  property p_step;
    $rose(reg_wr_en) && !pointer_step_off |-> ##2 reg_addr == $past(reg_addr, 2) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("pointer did not step");
  property p_freeze;
    (pointer_step_off && !pointer_select && !serial_iface_select_strap) [*8] |-> $stable(reg_addr);
  endproperty
  a_freeze: assert property (p_freeze) else $error("pointer moved while frozen");
  property p_serial;
    serial_iface_select_strap [*3] |-> !host_ready_n_oe && host_data_bus_oe[7:1] == 7'h00;
  endproperty
  a_serial: assert property (p_serial) else $error("parallel pins used in serial mode");
  c_read: cover property (host_data_bus_oe == 8'hff);
  c_ack: cover property (serial_iface_select_strap && host_data_bus_oe[0]);
  c_freeze: cover property (pointer_step_off && reg_wr_en);
endmodule : hrap_port_monitor

bind hrap_port hrap_port_monitor u_mon (.clk(clk), .reset_n(reset_n),
  .serial_iface_select_strap(serial_iface_select_strap), .chip_select_n(chip_select_n),
  .host_read_select(host_read_select), .pointer_select(pointer_select), .host_data_bus_oe(host_data_bus_oe),
  .host_ready_n_out(host_ready_n_out), .host_ready_n_oe(host_ready_n_oe),
  .pointer_step_off(pointer_step_off), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en));

/* verification/hrap_host.sv */
// Host partner: parallel master and serial bus master
`timescale 1ns/1ps
module hrap_host (
  input wire logic clk,
  input wire logic rdy_pin_n,
  input wire logic [7:0] bus_pin,
  output logic cs_n,
  output logic rw,
  output logic psel,
  output logic [7:0] h_out,
  output logic h_oe,
  output logic sda_low
);
  // ----------------------------------------------------------------
  // Parallel cycles and serial frames
  // ----------------------------------------------------------------
  localparam real Q = 31.25;
  initial
  begin
    cs_n = 1'b1;
    rw = 1'b0;
    psel = 1'b0;
    h_out = 8'h00;
    h_oe = 1'b0;
    sda_low = 1'b0;
  end
  task automatic par(input logic r, input logic p, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(negedge clk);
    rw = r;
    psel = p;
    h_out = d;
    h_oe = !r;
    cs_n = 1'b0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (rdy_pin_n !== 1'b0 && n < 30);
    q = (n < 30) ? bus_pin : 8'hxx;
    cs_n = 1'b1;
    h_oe = 1'b0;
    repeat (5) @(negedge clk);
  endtask : par
  task automatic sbit(input logic b, output logic r);
    sda_low = !b;
    #Q;
    cs_n = 1'b1;
    #Q;
    r = bus_pin[0];
    #Q;
    cs_n = 1'b0;
    #Q;
  endtask : sbit
  task automatic sbyte(input logic [8:0] v, output logic [8:0] r);
    logic t;
    for (int i = 8; i >= 0; i--)
    begin
      sbit(v[i], t);
      r[i] = t;
    end
  endtask : sbyte
  task automatic start;
    sda_low = 1'b0;
    cs_n = 1'b1;
    #Q;
    sda_low = 1'b1;
    #Q;
    cs_n = 1'b0;
    #Q;
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    #Q;
    cs_n = 1'b1;
    #Q;
    sda_low = 1'b0;
    #Q;
  endtask : stop
endmodule : hrap_host

/* verification/host_register_access_port_tb_top.sv */
// Self-checking bench for the host register access port
`timescale 1ns/1ps
module host_register_access_port_tb_top;
  import hrap_pkg::*;
  // ----------------------------------------------------------------
  // Pins, register file and model
  // ----------------------------------------------------------------
  localparam logic [6:0] SL = SLAVE_ADDR_DEFAULT;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic strap = 1'b0;
  logic off = 1'b0;
  logic [7:0] noise = 8'h5a;
  logic [7:0] rd_data;
  logic [7:0] bus, dev_out, dev_oe, addr, wr_data, h_out;
  logic cs_n, rw, psel, h_oe, sda_low, rdy, rdy_out, rdy_oe, wr_en, rd_en;
  logic [7:0] rf [256];
  int m [256];
  int ptr = 0;
  int seed = 24159;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  assign bus = strap ? {noise[7:1], !(dev_oe[0] | sda_low)} :
    (dev_oe & dev_out) | (~dev_oe & (h_oe ? h_out : noise));
  assign rdy = rdy_oe ? rdy_out : 1'b1;
  assign rd_data = rd_en ? rf[addr] : noise;
  hrap_port #(.SLAVE_ADDR(SL)) uut (.clk(clk), .reset_n(reset_n), .serial_iface_select_strap(strap),
    .chip_select_n(cs_n), .host_read_select(rw), .pointer_select(psel), .host_data_bus_in(bus),
    .host_data_bus_out(dev_out), .host_data_bus_oe(dev_oe), .host_ready_n_out(rdy_out),
    .host_ready_n_oe(rdy_oe), .pointer_step_off(off), .reg_addr(addr), .reg_wr_en(wr_en),
    .reg_wr_data(wr_data), .reg_rd_en(rd_en), .reg_rd_data(rd_data));
  hrap_host host (.clk(clk), .rdy_pin_n(rdy), .bus_pin(bus), .cs_n(cs_n), .rw(rw), .psel(psel),
    .h_out(h_out), .h_oe(h_oe), .sda_low(sda_low));
  initial
  begin
    forever #2 clk = ~clk;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
  end
  always @(posedge clk)
  begin
    noise <= ~noise;
    if (wr_en) rf[addr] <= wr_data;
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic pw(input logic p, input logic [7:0] d);
    logic [7:0] q;
    host.par(1'b0, p, d, q);
    if (p) ptr = d;
    else
    begin
      m[ptr] = d;
      ptr = (ptr + 1 - off) & 255;
    end
  endtask : pw
  task automatic pr(input logic p);
    logic [7:0] q;
    host.par(1'b1, p, 8'h00, q);
    chk("par_read", {1'b0, q}, {1'b0, p ? 8'(ptr) : 8'(m[ptr])});
    if (!p) ptr = (ptr + 1 - off) & 255;
  endtask : pr
  task automatic sb(input logic [8:0] v, input logic [8:0] e, input logic [8:0] k);
    logic [8:0] r;
    host.sbyte(v, r);
    chk("serial_byte", r & k, e & k);
  endtask : sb
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] b;
    logic [7:0] d;
    b = 8'($random(seed));
    d = 8'h00;
    @(posedge reset_n);
    repeat (3) @(negedge clk);
    pw(1'b1, b);
    repeat (4) pw(1'b0, 8'($random(seed)));
    pr(1'b1);
    pw(1'b1, b);
    repeat (4) pr(1'b0);
    $display("test parallel done");
    off = 1'b1;
    pw(1'b1, b);
    repeat (2) pw(1'b0, 8'($random(seed)));
    pr(1'b0);
    pr(1'b1);
    off = 1'b0;
    $display("test freeze done");
    strap = 1'b1;
    repeat (10) @(negedge clk);
    b = 8'($random(seed)) | 8'h80;
    host.start();
    sb({SL, 2'b01}, 9'h000, 9'h001);
    sb({b, 1'b1}, 9'h000, 9'h001);
    ptr = b & 127;
    repeat (3)
    begin
      d = 8'($random(seed));
      sb({d, 1'b1}, 9'h000, 9'h001);
      m[ptr] = d;
      ptr = (ptr + 1) & 255;
    end
    host.stop();
    host.start();
    sb({SL, 2'b01}, 9'h000, 9'h001);
    sb({b, 1'b1}, 9'h000, 9'h001);
    ptr = b & 127;
    host.stop();
    host.start();
    sb({SL, 2'b11}, 9'h000, 9'h001);
    sb(9'h1fe, {1'b0, 7'(ptr), 1'b0}, 9'h1fe);
    for (int i = 0; i < 3; i++)
    begin
      sb({8'hff, i == 2}, {8'(m[ptr]), 1'b0}, 9'h1fe);
      ptr = (ptr + 1) & 255;
    end
    ptr = (ptr + 1) & 255;
    host.stop();
    host.start();
    sb({SL ^ 7'h01, 2'b01}, 9'h001, 9'h001);
    host.stop();
    $display("test serial done");
    @(negedge clk);
    strap = 1'b0;
    repeat (10) @(negedge clk);
    pr(1'b1);
    $display("test shared pointer done");
    close_out();
  end
endmodule : host_register_access_port_tb_top
